/* File: dv/supply_comparator_model.sv */
`timescale 1ns/1ps

// Far-side analog comparator: thresholds in millivolts, reference settles after a delay
module supply_comparator_model #(
	parameter int SETTLE_CYCLES = 20
) (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic [3:0]  trip_level_code,
	input  wire logic [11:0] supply_mv,
	input  wire logic [11:0] ext_trip_mv,
	output logic             int_supply_ge,
	output logic             int_supply_le,
	output logic             ext_supply_ge,
	output logic             ext_supply_le,
	output logic             reference_stable_in
);
	logic [11:0] thr_mv;
	int          settle_cnt;

	// Trip point falls as the code rises from 4 to A; all other codes give 3000 mV
	always_comb begin
		case (trip_level_code)
			4'h4: thr_mv = 12'hE06;
			4'h5: thr_mv = 12'hD70;
			4'h6: thr_mv = 12'hC3A;
			4'h7: thr_mv = 12'hB68;
			4'h8: thr_mv = 12'hAFA;
			4'h9: thr_mv = 12'hA28;
			4'hA: thr_mv = 12'h9C4;
			default: thr_mv = 12'hBB8;
		endcase
	end

	assign int_supply_ge = (supply_mv >= thr_mv);
	assign int_supply_le = (supply_mv <= thr_mv);
	assign ext_supply_ge = (supply_mv >= ext_trip_mv);
	assign ext_supply_le = (supply_mv <= ext_trip_mv);

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst)
			settle_cnt <= 0;
		else if (settle_cnt < SETTLE_CYCLES)
			settle_cnt <= settle_cnt + 1;
	end
	assign reference_stable_in = (settle_cnt == SETTLE_CYCLES);
endmodule // supply_comparator_model

/* File: dv/tb.sv */
`timescale 1ns/1ps
`include "supply_level_detector_cfg.svh"

module tb;
	import supply_level_detector_pkg::*;
	logic        clk_sys, rst, wr_stb, rd_stb, ige, ile, ege, ele, ref_in;
	logic        det_en, cross_dir, chip_reset_req, irq, dir, ev;
	logic [7:0]  addr;
	logic [31:0] wr_data, rd_data, d;
	logic [11:0] supply_mv, ext_trip_mv;
	trip_code_t  trip_code, code;
	int          err_total, n_compared, cycles;
	logic [7:0]  al_ofs [4] = '{`SLD_OFS_SET, `SLD_OFS_CLR, `SLD_OFS_INV, `SLD_OFS_SET};
	logic [31:0] al_dat [4] = '{32'h3, 32'h1, 32'h801, 32'hFFFF_0000};
	logic [31:0] al_exp [4] = '{32'h807, 32'h806, 32'h007, 32'h007};

	supply_level_detect_ctrl u_supply_level_detect_ctrl (.clk_sys(clk_sys), .rst(rst), .addr(addr),
		.wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .int_supply_ge(ige),
		.int_supply_le(ile), .ext_supply_ge(ege), .ext_supply_le(ele), .reference_stable_in(ref_in),
		.detector_enable(det_en), .crossing_direction(cross_dir), .trip_level_code(trip_code),
		.chip_reset_req(chip_reset_req), .irq(irq));
	supply_comparator_model u_supply_comparator_model (.clk_sys(clk_sys), .rst(rst), .trip_level_code(trip_code),
		.supply_mv(supply_mv), .ext_trip_mv(ext_trip_mv), .int_supply_ge(ige), .int_supply_le(ile),
		.ext_supply_ge(ege), .ext_supply_le(ele), .reference_stable_in(ref_in));

	always #4 clk_sys = ~clk_sys;

	////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] dat);
		@(posedge clk_sys);
		addr    <= a;
		wr_data <= dat;
		wr_stb  <= 1'h1;
		@(posedge clk_sys);
		wr_stb  <= 1'h0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
		@(posedge clk_sys);
		addr   <= a;
		rd_stb <= 1'h1;
		@(posedge clk_sys);
		rd_stb <= 1'h0;
		#1;
		chk(rd_data, exp, what);
	endtask

	// Event expected for a rise to 3000 mV (dir 1) or a fall to 3000 mV (dir 0)
	function automatic logic exp_event(input trip_code_t c, input logic up);
		if (c == `SLD_LEVEL_EXT)
			return 1'h1;
		if (c < `SLD_LEVEL_INT_LO || c > `SLD_LEVEL_INT_HI)
			return 1'h0;
		return up ? (c >= 4'h7) : (c <= 4'h6);
	endfunction

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 2000) begin
			err_total++;
			$display("unexpected at %0t: run did not finish", $time);
			end_of_test();
		end
	end

	////////////////////////////////////////////////////////////////
	initial begin
		clk_sys = 1'h0; rst = 1'h1; addr = 8'h00; wr_data = 32'h0; wr_stb = 1'h0; rd_stb = 1'h0;
		supply_mv = 12'hFA0; ext_trip_mv = 12'hBB8; err_total = 0; n_compared = 0; cycles = 0;
		void'($urandom(32'hE40C));
		repeat (6) @(posedge clk_sys);
		rst <= 1'h0;
		rd(`SLD_OFS_CTRL, 32'h0, "ctrl at reset");
		repeat (25) @(posedge clk_sys);
		rd(`SLD_OFS_IMASK, 32'h0, "imask reset");
		wr(`SLD_OFS_IMASK, 32'h2);
		rd(`SLD_OFS_CTRL, 32'h400, "ctrl stable");
		chk(32'(irq), 32'h1, "irq reference");
		rd(`SLD_OFS_ISTAT, 32'h2, "istat stable");
		rd(`SLD_OFS_ISTAT, 32'h0, "istat cleared");
		chk(32'(irq), 32'h0, "irq reference cleared");
		rd(`SLD_OFS_IMASK, 32'h2, "imask rw");
		rd(8'h20, 32'h0, "unmapped read");
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			d = $urandom();
			d[15] = 1'h0;
			wr(`SLD_OFS_CTRL, d);
			wr(8'h20, ~d);
			#1;
			chk(32'({cross_dir, trip_code}), 32'({d[11], d[3:0]}), "outputs");
			chk(32'(chip_reset_req), 32'h0, "disabled reset");
			rd(`SLD_OFS_CTRL, (d & 32'h080F) | 32'h400, "ctrl rw");
		end
		$display("test register done");
		wr(`SLD_OFS_CTRL, 32'h805);
		for (int i = 0; i < 4; i++) begin
			wr(al_ofs[i], al_dat[i]);
			rd(`SLD_OFS_CTRL, al_exp[i] | 32'h400, "alias");
		end
		$display("test alias done");
		for (int k = 0; k < 32; k++) begin
			dir = k[4];
			code = k[3:0];
			ev = exp_event(code, dir);
			wr(`SLD_OFS_CLR, 32'h0000_FFFF);
			wr(`SLD_OFS_IMASK, 32'(dir));
			supply_mv <= dir ? 12'h000 : 12'hFA0;
			wr(`SLD_OFS_CTRL, (32'(dir) << 11) | 32'(code));
			wr(`SLD_OFS_SET, 32'h8000);
			@(posedge clk_sys);
			supply_mv <= 12'hBB8;
			@(posedge clk_sys);
			#1;
			chk(32'(chip_reset_req), 32'(ev), "reset request");
			@(posedge clk_sys);
			#1;
			chk(32'(chip_reset_req), 32'h0, "reset pulse end");
			chk(32'(irq), 32'(ev & dir), "irq level");
			chk(32'(det_en), 32'h1, "enable output");
			rd(`SLD_OFS_CTRL, 32'h8400 | (32'(dir) << 11) | 32'(code) | (32'(ev) << 8), "event bit");
			rd(`SLD_OFS_ISTAT, 32'(ev), "istat event");
			@(posedge clk_sys);
			#1;
			chk(32'(irq), 32'h0, "irq after read");
		end
		$display("test detect done");
		wr(`SLD_OFS_SET, 32'h0);
		rd(`SLD_OFS_CTRL, 32'h8D0F, "set keeps event");
		wr(`SLD_OFS_CLR, 32'h100);
		rd(`SLD_OFS_CTRL, 32'h8C0F, "event cleared by software");
		wr(`SLD_OFS_CLR, 32'h8000);
		rd(`SLD_OFS_CTRL, 32'h0C0F, "event cleared");
		supply_mv <= 12'h000;
		@(posedge clk_sys);
		supply_mv <= 12'hBB8;
		repeat (2) @(posedge clk_sys);
		#1;
		chk(32'({chip_reset_req, irq, det_en}), 32'h0, "disabled quiet");
		rd(`SLD_OFS_ISTAT, 32'h0, "istat quiet");
		$display("test disable done");
		end_of_test();
	end
endmodule // tb

/* File: logic/sticky_flag.sv */
`timescale 1ns/1ps

module sticky_flag (
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic set_pulse,
	input  wire logic clear_pulse,
	output logic      flag
);

	logic flag_reg;
	logic flag_next;

	// Set wins over a clear in the same cycle
	assign flag_next = set_pulse | (flag_reg & ~clear_pulse);
	assign flag      = flag_reg;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			flag_reg <= 1'b0;
		end else begin
			flag_reg <= flag_next;
		end
	end

endmodule // sticky_flag

/* File: logic/supply_level_detect_ctrl.sv */
`timescale 1ns/1ps
`include "supply_level_detector_cfg.svh"

// Behaviour
// RULE1 - Control bit 15 enables the detector; clear disables it.
// RULE2 - Bit 11 picks direction: 1 at-or-above trip, 0 at-or-below trip.
// RULE3 - Bit 10 reads reference-voltage-stable status, read only.
// RULE4 - Reference-stable status stays readable while detector disabled.
// RULE5 - Bit 8 shows whether the detection event interrupt is active.
// RULE6 - Trip code 1111 compares against the external trip input.
// RULE7 - Codes 0100 to 1010 select seven internal thresholds, falling with code.
// RULE8 - Software must not program reserved codes 1011-1110 and 0000-0011.
// RULE9 - Software should change direction and level only while disabled.
// RULE10 - A detection event while enabled requests a chip reset.
// RULE11 - A detection event in the chosen direction raises an interrupt request.
// RULE12 - Unimplemented bits, including 31 to 16, read zero and ignore writes.
// RULE13 - Offsets 0x4, 0x8, 0xC clear, set and invert writable bits.
// RULE14 - While disabled, no events, resets or interrupts; event bit kept clear. The code still raises the reference-stable interrupt while disabled.
module supply_level_detect_ctrl
	import supply_level_detector_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input  wire logic              clk_sys,
	input  wire logic              rst,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [31:0]       wr_data,
	input  wire logic              wr_stb,
	input  wire logic              rd_stb,
	output logic      [31:0]       rd_data,
	input  wire logic              int_supply_ge,
	input  wire logic              int_supply_le,
	input  wire logic              ext_supply_ge,
	input  wire logic              ext_supply_le,
	input  wire logic              reference_stable_in,
	output logic                   detector_enable,
	output logic                   crossing_direction,
	output trip_code_t             trip_level_code,
	output logic                   chip_reset_req,
	output logic                   irq
);

	////////////////////////////////////////////////////////////////////////
	// Declarations

	logic [31:0] ctrl_reg;
	logic [31:0] ctrl_next;
	logic [31:0] ctrl_wr_val;
	logic [31:0] ctrl_view;
	logic [31:0] rd_data_reg;
	logic [31:0] rd_data_next;
	logic [1:0]  imask_reg;
	logic [1:0]  imask_next;
	logic [1:0]  istat;
	logic        ref_stable_reg;
	logic        ref_stable_prev_reg;
	logic        cond_prev_reg;
	logic        chip_reset_req_reg;
	logic        irq_reg;
	logic        irq_next;
	logic        det_flag_reg;
	logic        det_flag_next;
	logic        out_en_reg;
	logic        out_dir_reg;
	trip_code_t  out_level_reg;

	reg_sel_t    sel;
	logic        wr_ctrl_any;
	logic        rd_istat;
	logic        en_bit;
	logic        dir_bit;
	trip_code_t  level_code;
	trip_code_t  level_next;
	logic        level_is_ext;
	logic        level_is_int;
	logic        level_valid;
	logic        supply_ge;
	logic        supply_le;
	logic        cond_now;
	logic        event_pulse;
	logic        en_next;
	logic        det_clear_by_sw;
	logic        ref_rise;

	////////////////////////////////////////////////////////////////////////
	// Address decode

	assign sel = (addr == `SLD_OFS_CTRL)  ? SEL_CTRL  :
	             (addr == `SLD_OFS_CLR)   ? SEL_CLR   :
	             (addr == `SLD_OFS_SET)   ? SEL_SET   :
	             (addr == `SLD_OFS_INV)   ? SEL_INV   :
	             (addr == `SLD_OFS_ISTAT) ? SEL_ISTAT :
	             (addr == `SLD_OFS_IMASK) ? SEL_IMASK : SEL_NONE;

	assign wr_ctrl_any = wr_stb & (sel == SEL_CTRL || sel == SEL_CLR || sel == SEL_SET || sel == SEL_INV);
	assign rd_istat    = rd_stb & (sel == SEL_ISTAT);

	////////////////////////////////////////////////////////////////////////
	// Control word writes with clear, set and invert aliases

	// Aliases act on the visible word, so the event bit follows what software reads
	assign ctrl_wr_val = (sel == SEL_CLR) ? (ctrl_view & ~wr_data) : // RULE13
	                     (sel == SEL_SET) ? (ctrl_view | wr_data)  : // RULE13
	                     (sel == SEL_INV) ? (ctrl_view ^ wr_data)  : // RULE13
	                     wr_data;

	// Only writable bits ever change; all others hold zero
	assign ctrl_next = wr_ctrl_any ? (ctrl_wr_val & `SLD_CTRL_WMASK) : ctrl_reg; // RULE12

	assign en_bit     = ctrl_reg[`SLD_BIT_ENABLE]; // RULE1
	assign dir_bit    = ctrl_reg[`SLD_BIT_DIR]; // RULE2
	assign level_code = ctrl_reg[`SLD_LEVEL_MSB:`SLD_LEVEL_LSB];
	assign en_next    = ctrl_next[`SLD_BIT_ENABLE];
	assign level_next = ctrl_next[`SLD_LEVEL_MSB:`SLD_LEVEL_LSB];

	// Software write of zero to the event bit clears it
	assign det_clear_by_sw = wr_ctrl_any & ~ctrl_next[`SLD_BIT_EVENT];

	////////////////////////////////////////////////////////////////////////
	// Trip level selection and crossing detection

	assign level_is_ext = (level_code == `SLD_LEVEL_EXT); // RULE6
	assign level_is_int = (level_code >= `SLD_LEVEL_INT_LO) && (level_code <= `SLD_LEVEL_INT_HI); // RULE7
	assign level_valid  = level_is_ext | level_is_int;

	assign supply_ge = level_is_ext ? ext_supply_ge : int_supply_ge; // RULE6
	assign supply_le = level_is_ext ? ext_supply_le : int_supply_le; // RULE6

	// Direction picks which side of the trip point counts as an event
	assign cond_now = level_valid & (dir_bit ? supply_ge : supply_le); // RULE2

	// A new event is the start of the condition while enabled
	assign event_pulse = en_bit & cond_now & ~cond_prev_reg; // RULE14

	// Event bit: hardware set wins over software clear; forced low while disabled
	assign det_flag_next = en_next & (event_pulse | (det_flag_reg & ~det_clear_by_sw)); // RULE14

	assign ref_rise = ref_stable_reg & ~ref_stable_prev_reg;

	////////////////////////////////////////////////////////////////////////
	// Interrupt status, mask and output

	sticky_flag u_istat_detect (
		.clk_sys     (clk_sys),
		.rst         (rst),
		.set_pulse   (event_pulse),
		.clear_pulse (rd_istat),
		.flag        (istat[`SLD_IRQ_DETECT])
	); // RULE11

	sticky_flag u_istat_ref (
		.clk_sys     (clk_sys),
		.rst         (rst),
		.set_pulse   (ref_rise),
		.clear_pulse (rd_istat),
		.flag        (istat[`SLD_IRQ_REF_STABLE])
	);

	assign imask_next = (wr_stb && sel == SEL_IMASK) ? wr_data[1:0] : imask_reg;
	assign irq_next   = |(istat & imask_reg); // RULE11

	////////////////////////////////////////////////////////////////////////
	// Read path

	assign ctrl_view = {ctrl_reg[31:11], ref_stable_reg, ctrl_reg[9], det_flag_reg, ctrl_reg[7:0]}; // RULE3 RULE4 RULE5

	assign rd_data_next = ~rd_stb                                  ? 32'h0000_0000 :
	                      (sel == SEL_ISTAT)                       ? {30'h0000_0000, istat} :
	                      (sel == SEL_IMASK)                       ? {30'h0000_0000, imask_reg} :
	                      (sel == SEL_NONE)                        ? 32'h0000_0000 :
	                      ctrl_view; // RULE12

	////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ctrl_reg <= `SLD_CTRL_RESET;
			imask_reg <= `SLD_IMASK_RESET;
			det_flag_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			imask_reg <= imask_next;
			det_flag_reg <= det_flag_next; // RULE5
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cond_prev_reg <= 1'b0;
			ref_stable_reg <= 1'b0;
			ref_stable_prev_reg <= 1'b0;
		end else begin
			cond_prev_reg <= cond_now & en_bit;
			ref_stable_reg <= reference_stable_in; // RULE4
			ref_stable_prev_reg <= ref_stable_reg;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			chip_reset_req_reg <= 1'b0;
			irq_reg <= 1'b0;
			rd_data_reg <= 32'h0000_0000;
		end else begin
			chip_reset_req_reg <= event_pulse; // RULE10
			irq_reg <= irq_next;
			rd_data_reg <= rd_data_next;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			out_en_reg <= 1'b0;
			out_dir_reg <= 1'b0;
			out_level_reg <= 4'h0;
		end else begin
			out_en_reg <= en_next; // RULE1
			out_dir_reg <= ctrl_next[`SLD_BIT_DIR];
			out_level_reg <= level_next;
		end
	end

	assign rd_data            = rd_data_reg;
	assign chip_reset_req     = chip_reset_req_reg;
	assign irq                = irq_reg;
	assign detector_enable    = out_en_reg;
	assign crossing_direction = out_dir_reg;
	assign trip_level_code    = out_level_reg;

	////////////////////////////////////////////////////////////////////////
	// Assertions

	sequence seq_rise_above;
		en_bit && dir_bit && level_valid && supply_ge && !cond_prev_reg;
	endsequence

	sequence seq_fall_below;
		en_bit && !dir_bit && level_valid && supply_le && !cond_prev_reg;
	endsequence

	// Event bit follows the enable output: set while enabled, cleared if disabled at the same edge
	sequence seq_event_reported;
		chip_reset_req_reg && (det_flag_reg == detector_enable);
	endsequence

	property p_event_effects;
		@(posedge clk_sys) disable iff (rst)
		(seq_rise_above or seq_fall_below) |=> seq_event_reported;
	endproperty

	AST_EVENT_REPORTED: assert property (p_event_effects) // RULE10
		else $error("Detection did not set event bit and reset request");

	AST_DIR_BLOCKS: assert property (@(posedge clk_sys) disable iff (rst) // RULE2
		(dir_bit && !supply_ge) || (!dir_bit && !supply_le) |-> !event_pulse)
		else $error("Event fired in the wrong direction");

	AST_DISABLED_QUIET: assert property (@(posedge clk_sys) disable iff (rst) // RULE14
		!en_bit |-> !det_flag_reg && !event_pulse ##1 !chip_reset_req_reg)
		else $error("Activity while detector disabled");

	AST_ENABLE_PIN: assert property (@(posedge clk_sys) disable iff (rst) // RULE1
		detector_enable == en_bit)
		else $error("Detector enable output disagrees with control bit");

	AST_REF_READ: assert property (@(posedge clk_sys) disable iff (rst) // RULE3
		rd_stb && sel == SEL_CTRL |=> rd_data[`SLD_BIT_REF_STABLE] == $past(ref_stable_reg))
		else $error("Reference stable bit misreported");

	AST_EVENT_BIT_READ: assert property (@(posedge clk_sys) disable iff (rst) // RULE5
		rd_stb && sel == SEL_CTRL |=> rd_data[`SLD_BIT_EVENT] == $past(det_flag_reg))
		else $error("Event bit misreported");

	AST_UPPER_ZERO: assert property (@(posedge clk_sys) disable iff (rst) // RULE12
		rd_data[31:16] == 16'h0000 && ctrl_reg[31:16] == 16'h0000)
		else $error("Unimplemented bits not zero");

	AST_EXT_LEVEL: assert property (@(posedge clk_sys) disable iff (rst) // RULE6
		level_is_ext && !ext_supply_ge && !ext_supply_le |-> !event_pulse)
		else $error("External trip input ignored");

	AST_RESERVED_CODE: assert property (@(posedge clk_sys) disable iff (rst) // RULE7
		!level_is_ext && (level_code < 4'h4 || level_code > 4'hA) |-> !event_pulse)
		else $error("Event on reserved trip code");

	AST_SET_ALIAS: assert property (@(posedge clk_sys) disable iff (rst) // RULE13
		wr_stb && sel == SEL_SET && wr_data[`SLD_BIT_ENABLE] |=> en_bit && detector_enable)
		else $error("Set alias did not set enable");

	AST_CLR_ALIAS: assert property (@(posedge clk_sys) disable iff (rst) // RULE13
		wr_stb && sel == SEL_CLR && wr_data[`SLD_BIT_DIR] |=> !dir_bit)
		else $error("Clear alias did not clear direction");

	AST_INV_ALIAS: assert property (@(posedge clk_sys) disable iff (rst) // RULE13
		wr_stb && sel == SEL_INV && wr_data[`SLD_BIT_DIR] |=> dir_bit != $past(dir_bit))
		else $error("Invert alias did not flip direction");

	AST_IRQ_OUT: assert property (@(posedge clk_sys) disable iff (rst) // RULE11
		event_pulse && imask_reg[`SLD_IRQ_DETECT] && !(wr_stb && sel == SEL_IMASK) |=> ##1 irq)
		else $error("Unmasked detection did not raise interrupt");

	AST_RESET_ONE_CYCLE: assert property (@(posedge clk_sys) disable iff (rst) // RULE10
		chip_reset_req |=> !chip_reset_req)
		else $error("Chip reset request longer than one cycle");

	AST_RESET_CAUSE: assert property (@(posedge clk_sys) disable iff (rst) // RULE10
		1'b1 |=> chip_reset_req == $past(event_pulse))
		else $error("Chip reset request does not follow detection");

	AST_ISTAT_SET: assert property (@(posedge clk_sys) disable iff (rst) // RULE11
		event_pulse |=> istat[`SLD_IRQ_DETECT])
		else $error("Detection did not set interrupt status");

	AST_ISTAT_CLEAR: assert property (@(posedge clk_sys) disable iff (rst) // RULE11
		rd_istat && !event_pulse && !ref_rise |=> istat == 2'h0)
		else $error("Status read did not clear interrupt status");

	AST_IRQ_LEVEL: assert property (@(posedge clk_sys) disable iff (rst) // RULE11
		1'b1 |=> irq == $past(irq_next))
		else $error("Interrupt output disagrees with masked status");

	AST_RD_IDLE_ZERO: assert property (@(posedge clk_sys) disable iff (rst) // RULE12
		!rd_stb |=> rd_data == 32'h0000_0000)
		else $error("Read data not zero outside a read");

	AST_UNMAPPED_WRITE: assert property (@(posedge clk_sys) disable iff (rst) // RULE12
		wr_stb && sel == SEL_NONE |=> $stable(ctrl_reg) && $stable(imask_reg))
		else $error("Unmapped write changed a register");

	AST_REF_TRACKS: assert property (@(posedge clk_sys) disable iff (rst) // RULE4
		1'b1 |=> ref_stable_reg == $past(reference_stable_in))
		else $error("Reference stable bit does not follow its input");

	AST_EVENT_HOLD: assert property (@(posedge clk_sys) disable iff (rst) // RULE5
		det_flag_reg && en_next && !det_clear_by_sw |=> det_flag_reg)
		else $error("Event bit dropped without a clear");

	AST_EVENT_SW_CLEAR: assert property (@(posedge clk_sys) disable iff (rst) // RULE5
		det_clear_by_sw && !event_pulse |=> !det_flag_reg)
		else $error("Software clear of event bit ignored");

	AST_SETTING_PINS: assert property (@(posedge clk_sys) disable iff (rst) // RULE2
		crossing_direction == dir_bit && trip_level_code == level_code)
		else $error("Setting outputs disagree with control word");

	AST_EVENT_NEEDS_DROP: assert property (@(posedge clk_sys) disable iff (rst) // RULE14
		cond_prev_reg |-> !event_pulse)
		else $error("Second event without the condition dropping");

endmodule // supply_level_detect_ctrl

/* File: logic/supply_level_detector_cfg.svh */
`ifndef SUPPLY_LEVEL_DETECTOR_CFG_SVH
`define SUPPLY_LEVEL_DETECTOR_CFG_SVH

// Register byte offsets
`define SLD_OFS_CTRL        8'h00
`define SLD_OFS_CLR         8'h04
`define SLD_OFS_SET         8'h08
`define SLD_OFS_INV         8'h0C
`define SLD_OFS_ISTAT       8'h10
`define SLD_OFS_IMASK       8'h14

// Control word field positions
`define SLD_BIT_ENABLE      15
`define SLD_BIT_DIR         11
`define SLD_BIT_REF_STABLE  10
`define SLD_BIT_EVENT       8
`define SLD_LEVEL_MSB       3
`define SLD_LEVEL_LSB       0

// Writable bits of the control word
`define SLD_CTRL_WMASK      32'h0000_890F

// Reset values
`define SLD_CTRL_RESET      32'h0000_0000
`define SLD_IMASK_RESET     2'h0

// Trip level codes
`define SLD_LEVEL_EXT       4'hF
`define SLD_LEVEL_INT_LO    4'h4
`define SLD_LEVEL_INT_HI    4'hA

// Interrupt status bit positions
`define SLD_IRQ_DETECT      0
`define SLD_IRQ_REF_STABLE  1

`endif

/* File: logic/supply_level_detector_pkg.sv */
package supply_level_detector_pkg;

	typedef enum logic [2:0] {
		SEL_CTRL  = 3'h0,
		SEL_CLR   = 3'h1,
		SEL_SET   = 3'h2,
		SEL_INV   = 3'h3,
		SEL_ISTAT = 3'h4,
		SEL_IMASK = 3'h5,
		SEL_NONE  = 3'h7
	} reg_sel_t;

	typedef logic [3:0] trip_code_t;

endpackage
